// ---- src/dps_defines.svh ----
// Purpose: Offsets, field positions, reset values and counts of the
//          program sequencer.
// Assumes: Byte addresses on a 32-bit classic Wishbone slave.
// Notes:   Definitions only.
`ifndef DPS_DEFINES_SVH
`define DPS_DEFINES_SVH

`define DPS_ADDR_W          14
`define DPS_PC_DEPTH        16
`define DPS_LOOP_DEPTH      4
`define DPS_CNT_DEPTH       4
`define DPS_VECTOR_SPACING  4

`define DPS_OFS_LOOP_COUNT  8'h00
`define DPS_OFS_OVERWRITE   8'h04
`define DPS_OFS_STATUS      8'h08
`define DPS_OFS_POP         8'h0C

`define DPS_POP_PC_BIT      0
`define DPS_POP_LOOP_BIT    1
`define DPS_POP_CNT_BIT     2

`define DPS_ST_PC_EMPTY     0
`define DPS_ST_CNT_EMPTY    1
`define DPS_ST_LOOP_EMPTY   2
`define DPS_ST_CNT_VALID    3
`define DPS_ST_FAULT_LSB    8

`define DPS_F_PC_OVF        0
`define DPS_F_PC_UNF        1
`define DPS_F_LOOP_OVF      2
`define DPS_F_LOOP_UNF      3
`define DPS_F_CNT_OVF       4
`define DPS_F_CNT_UNF       5

`define DPS_RST_PC          14'h0000
`define DPS_RST_CNT         14'h0000
`define DPS_CNT_EXPIRED     14'h0001

`endif

// ---- src/dps_pkg.sv ----
// Purpose: Types of the program sequencer.
// Assumes: Operation codes come from the instruction decoder.
// Notes:   State record holds every flip-flop of the sequencer.
package dps_pkg;

    typedef enum logic [3:0] {
        DPS_OP_SEQ      = 4'h0,
        DPS_OP_JUMP     = 4'h1,
        DPS_OP_CALL     = 4'h2,
        DPS_OP_RTS      = 4'h3,
        DPS_OP_RTI      = 4'h4,
        DPS_OP_DO       = 4'h5,
        DPS_OP_INDIRECT = 4'h6,
        DPS_OP_IDLE     = 4'h7
    } dps_op_t;

    typedef enum logic [3:0] {
        DPS_C_EQ      = 4'h0,
        DPS_C_NE      = 4'h1,
        DPS_C_LT      = 4'h2,
        DPS_C_GE      = 4'h3,
        DPS_C_LE      = 4'h4,
        DPS_C_GT      = 4'h5,
        DPS_C_AC      = 4'h6,
        DPS_C_NOT_AC  = 4'h7,
        DPS_C_AV      = 4'h8,
        DPS_C_NOT_AV  = 4'h9,
        DPS_C_MV      = 4'hA,
        DPS_C_NOT_MV  = 4'hB,
        DPS_C_NEG     = 4'hC,
        DPS_C_POS     = 4'hD,
        DPS_C_CE      = 4'hE,
        DPS_C_FOREVER = 4'hF
    } dps_cond_t;

    typedef struct packed {
        logic [13:0]       pc;
        logic [15:0][13:0] pcStack;
        logic [4:0]        pcDepth;
        logic [3:0][17:0]  loopStack;
        logic [2:0]        loopDepth;
        logic [3:0][13:0]  cntStack;
        logic [2:0]        cntDepth;
        logic [13:0]       cnt;
        logic              cntValid;
        logic [5:0]        fault;
        logic              stackError;
        logic              wbAck;
        logic [31:0]       wbDatOut;
    } dps_state_t;

endpackage

// ---- src/dps_program_sequencer.sv ----
// Purpose: Next-address selection, program counter, return, count and
//          loop stacks of a fixed-point signal processor.
// Assumes: Decoder inputs and flags are on sys_clk; counter and stack
//          control over classic Wishbone.
// Notes:   programAddress is the address of the executing instruction.
//
// Operation
// - Next address from incrementer, return stack, jump field or vector.
// - Incrementer for sequential flow, untaken branch, loop termination.
// - Return stack top on subroutine return, interrupt return, loop back.
// - Taken direct jump uses the instruction's jump field.
// - Interrupt branches to its vector; vectors four words apart.
// - Indirect jump loads the counter from the generator's address.
// - Fourteen-bit program counter feeding a plus-one incrementer.
// - Sixteen-entry return stack pushed with incrementer on call and loop.
// - Interrupt pushes current counter so aborted instruction refetches.
// - Counter loads the next address every cycle.
// - Count register write loads the low fourteen bits as count.
// - Expired means counter equals one; decrement follows the test.
// - Loop end or conditional jump testing expiry post-decrements.
// - Conditional return testing expiry does not decrement.
// - Counter reads any time unchanged; upper eighteen bits zero.
// - Four-entry count stack pushed with old count on load.
// - Expiry found true pops the count stack; software may pop.
// - No push when the counter holds no valid value.
// - Count stack empty when pops reach or exceed pushes.
// - Overwrite register replaces the count without pushing.
// - Comparator matches loop end; branches back with no extra cycle.
// - Loop termination conditions from ALU, MAC and x-input sign flags and expiry.
// - Loop setup pushes end and condition, and incrementer output.
// - Loop end: false branches back, true falls through and pops.
// - A taken transfer at loop end overrides all loop actions.
//
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "dps_defines.svh"

module dps_program_sequencer (
    input  wire logic            sys_clk,
    input  wire logic            reset,
    input  wire logic [7:0]      wbAdr,
    input  wire logic [31:0]     wbDatIn,
    input  wire logic [3:0]      wbSel,
    input  wire logic            wbWe,
    input  wire logic            wbCyc,
    input  wire logic            wbStb,
    output logic                 wbAck,
    output logic [31:0]          wbDatOut,
    input  wire dps_pkg::dps_op_t op,
    input  wire logic            condTrue,
    input  wire logic            condIsCe,
    input  wire logic [13:0]     jumpAddr,
    input  wire logic [13:0]     loopEndAddr,
    input  wire logic [3:0]      loopCond,
    input  wire logic [13:0]     indirectAddr,
    input  wire logic            irqTake,
    input  wire logic [2:0]      irqLevel,
    input  wire logic            aluZeroFlag,
    input  wire logic            aluNegativeFlag,
    input  wire logic            aluOverflowFlag,
    input  wire logic            aluCarryFlag,
    input  wire logic            macOverflowFlag,
    input  wire logic            xInputSignFlag,
    output logic [13:0]          programAddress,
    output logic                 stackError
);

    dps_pkg::dps_state_t r;
    dps_pkg::dps_state_t next_r;

    logic        ceTrue;
    logic        loopActive;
    logic        loopLast;
    logic        loopCondTrue;
    logic        xferTaken;
    logic [13:0] pcInc;
    logic [13:0] pcTop;
    logic [17:0] loopTop;
    logic [13:0] cntTop;
    logic        busWrite;

    // Expiry tested against the count held at the start of the cycle
    assign ceTrue     = r.cntValid && (r.cnt == `DPS_CNT_EXPIRED);
    assign pcInc      = r.pc + 14'h0001;
    assign pcTop      = r.pcStack[4'(r.pcDepth - 5'h01)];
    assign loopTop    = r.loopStack[2'(r.loopDepth - 3'h1)];
    assign cntTop     = r.cntStack[2'(r.cntDepth - 3'h1)];
    assign loopActive = (r.loopDepth != 3'h0);
    assign loopLast   = loopActive && (loopTop[17:4] == r.pc);
    assign busWrite   = wbCyc && wbStb && wbWe && r.wbAck && (|wbSel);

    always_comb begin
        case (dps_pkg::dps_cond_t'(loopTop[3:0]))
            dps_pkg::DPS_C_EQ:      loopCondTrue = aluZeroFlag;
            dps_pkg::DPS_C_NE:      loopCondTrue = !aluZeroFlag;
            dps_pkg::DPS_C_LT:
                loopCondTrue = aluNegativeFlag ^ aluOverflowFlag;
            dps_pkg::DPS_C_GE:
                loopCondTrue = !(aluNegativeFlag ^ aluOverflowFlag);
            dps_pkg::DPS_C_LE:
                loopCondTrue = (aluNegativeFlag ^ aluOverflowFlag)
                               || aluZeroFlag;
            dps_pkg::DPS_C_GT:
                loopCondTrue = !((aluNegativeFlag ^ aluOverflowFlag)
                                 || aluZeroFlag);
            dps_pkg::DPS_C_AC:      loopCondTrue = aluCarryFlag;
            dps_pkg::DPS_C_NOT_AC:  loopCondTrue = !aluCarryFlag;
            dps_pkg::DPS_C_AV:      loopCondTrue = aluOverflowFlag;
            dps_pkg::DPS_C_NOT_AV:  loopCondTrue = !aluOverflowFlag;
            dps_pkg::DPS_C_MV:      loopCondTrue = macOverflowFlag;
            dps_pkg::DPS_C_NOT_MV:  loopCondTrue = !macOverflowFlag;
            dps_pkg::DPS_C_NEG:     loopCondTrue = xInputSignFlag;
            dps_pkg::DPS_C_POS:     loopCondTrue = !xInputSignFlag;
            dps_pkg::DPS_C_CE:      loopCondTrue = ceTrue;
            dps_pkg::DPS_C_FOREVER: loopCondTrue = 1'b1;
            default:                loopCondTrue = 1'b1;
        endcase
    end

    // Explicit transfer condition; expiry tests use the counter
    always_comb begin
        case (op)
            dps_pkg::DPS_OP_JUMP, dps_pkg::DPS_OP_CALL,
            dps_pkg::DPS_OP_RTS, dps_pkg::DPS_OP_RTI,
            dps_pkg::DPS_OP_INDIRECT:
                xferTaken = condIsCe ? ceTrue : condTrue;
            default:
                xferTaken = 1'b0;
        endcase
    end

    always_comb begin
        logic        pcPush;
        logic [13:0] pcPushVal;
        logic        pcPop;
        logic        loopPush;
        logic        loopPop;
        logic        cntPop;
        logic        cntDec;
        logic [13:0] nextAddr;
        pcPush    = 1'b0;
        pcPushVal = pcInc;
        pcPop     = 1'b0;
        loopPush  = 1'b0;
        loopPop   = 1'b0;
        cntPop    = 1'b0;
        cntDec    = 1'b0;
        nextAddr  = pcInc;
        next_r    = r;

        if (irqTake) begin
            // Aborted instruction is refetched after the return
            nextAddr  = 14'((14'(irqLevel) + 14'h0001)
                            * 14'(`DPS_VECTOR_SPACING));
            pcPush    = 1'b1;
            pcPushVal = r.pc;
        end else if (xferTaken) begin
            case (op)
                dps_pkg::DPS_OP_JUMP: nextAddr = jumpAddr;
                dps_pkg::DPS_OP_CALL: begin
                    nextAddr = jumpAddr;
                    pcPush   = 1'b1;
                end
                dps_pkg::DPS_OP_RTS, dps_pkg::DPS_OP_RTI: begin
                    nextAddr = pcTop;
                    pcPop    = 1'b1;
                end
                dps_pkg::DPS_OP_INDIRECT: nextAddr = indirectAddr;
                default: nextAddr = pcInc;
            endcase
            if (condIsCe) begin
                cntPop = 1'b1;
                cntDec = (op == dps_pkg::DPS_OP_JUMP);
            end
        end else begin
            if (condIsCe && op == dps_pkg::DPS_OP_JUMP) begin
                cntDec = 1'b1;
            end
            if (op == dps_pkg::DPS_OP_DO) begin
                loopPush = 1'b1;
                pcPush   = 1'b1;
            end else if (op == dps_pkg::DPS_OP_IDLE) begin
                nextAddr = r.pc;
            end
            if (loopLast) begin
                if (loopTop[3:0] == 4'(dps_pkg::DPS_C_CE)) begin
                    cntDec = 1'b1;
                end
                if (loopCondTrue) begin
                    nextAddr = pcInc;
                    loopPop  = 1'b1;
                    pcPop    = 1'b1;
                    cntPop   = (loopTop[3:0] == 4'(dps_pkg::DPS_C_CE));
                end else begin
                    nextAddr = pcTop;
                end
            end
        end

        // Software count pop joins the instruction's own count pop; both make one pop
        if (busWrite && wbAdr == `DPS_OFS_POP) begin
            if (wbDatIn[`DPS_POP_CNT_BIT]) begin
                if (r.cntDepth == 3'h0) begin
                    next_r.fault[`DPS_F_CNT_UNF] = 1'b1;
                end else begin
                    cntPop = 1'b1;
                end
            end
        end

        // Counter: pop restores the outer count, else post-decrement
        if (cntPop) begin
            if (r.cntDepth != 3'h0) begin
                next_r.cnt      = cntTop;
                next_r.cntDepth = r.cntDepth - 3'h1;
            end else begin
                next_r.cntValid = 1'b0;
            end
        end else if (cntDec) begin
            next_r.cnt = r.cnt - 14'h0001;
        end

        // Return stack; a full push or empty pop touches nothing else
        if (pcPush) begin
            if (r.pcDepth == 5'(`DPS_PC_DEPTH)) begin
                next_r.fault[`DPS_F_PC_OVF] = 1'b1;
            end else begin
                next_r.pcStack[4'(r.pcDepth)] = pcPushVal;
                next_r.pcDepth = r.pcDepth + 5'h01;
            end
        end
        if (busWrite && wbAdr == `DPS_OFS_POP
            && wbDatIn[`DPS_POP_PC_BIT]) begin
            pcPop = 1'b1;
        end
        if (pcPop) begin
            if (next_r.pcDepth == 5'h00) begin
                next_r.fault[`DPS_F_PC_UNF] = 1'b1;
            end else begin
                next_r.pcDepth = next_r.pcDepth - 5'h01;
            end
        end

        // Loop stack of end address and termination condition
        if (loopPush) begin
            if (r.loopDepth == 3'(`DPS_LOOP_DEPTH)) begin
                next_r.fault[`DPS_F_LOOP_OVF] = 1'b1;
            end else begin
                next_r.loopStack[2'(r.loopDepth)] =
                    {loopEndAddr, loopCond};
                next_r.loopDepth = r.loopDepth + 3'h1;
            end
        end
        if (busWrite && wbAdr == `DPS_OFS_POP
            && wbDatIn[`DPS_POP_LOOP_BIT]) begin
            loopPop = 1'b1;
        end
        if (loopPop) begin
            if (next_r.loopDepth == 3'h0) begin
                next_r.fault[`DPS_F_LOOP_UNF] = 1'b1;
            end else begin
                next_r.loopDepth = next_r.loopDepth - 3'h1;
            end
        end

        // Count loads from the bus take precedence over the decrement
        if (busWrite && wbAdr == `DPS_OFS_LOOP_COUNT) begin
            if (r.cntValid) begin
                if (next_r.cntDepth == 3'(`DPS_CNT_DEPTH)) begin
                    next_r.fault[`DPS_F_CNT_OVF] = 1'b1;
                end else begin
                    next_r.cntStack[2'(next_r.cntDepth)] =
                        next_r.cnt;
                    next_r.cntDepth = next_r.cntDepth + 3'h1;
                end
            end
            next_r.cnt      = wbDatIn[13:0];
            next_r.cntValid = 1'b1;
        end else if (busWrite && wbAdr == `DPS_OFS_OVERWRITE) begin
            next_r.cnt      = wbDatIn[13:0];
            next_r.cntValid = 1'b1;
        end

        next_r.stackError = |next_r.fault;
        next_r.pc = nextAddr;

        // Bus slave: one wait state, ack drops after one cycle
        next_r.wbAck    = wbCyc && wbStb && !r.wbAck;
        next_r.wbDatOut = 32'h0000_0000;
        if (wbCyc && wbStb && !r.wbAck && !wbWe) begin
            case (wbAdr)
                `DPS_OFS_LOOP_COUNT:
                    next_r.wbDatOut = {18'h00000, r.cnt};
                `DPS_OFS_STATUS: begin
                    next_r.wbDatOut[`DPS_ST_PC_EMPTY] =
                        (r.pcDepth == 5'h00);
                    next_r.wbDatOut[`DPS_ST_CNT_EMPTY] =
                        (r.cntDepth == 3'h0);
                    next_r.wbDatOut[`DPS_ST_LOOP_EMPTY] = !loopActive;
                    next_r.wbDatOut[`DPS_ST_CNT_VALID] = r.cntValid;
                    next_r.wbDatOut[`DPS_ST_FAULT_LSB +: 6] = r.fault;
                end
                default: next_r.wbDatOut = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            r          <= '0;
            r.pc       <= `DPS_RST_PC;
            r.cnt      <= `DPS_RST_CNT;
            r.cntValid <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign programAddress = r.pc;
    assign stackError     = r.stackError;
    assign wbAck          = r.wbAck;
    assign wbDatOut       = r.wbDatOut;

endmodule // dps_program_sequencer

// ---- test/dps_program_memory.sv ----
// Purpose: Program memory answering the program address bus.
// Assumes: Word is {op, condTrue, condIsCe, jump, loop end, loop cond}.
// Notes:   Bench fills mem; unwritten words decode as sequential.
`timescale 1ns/1ps
module dps_program_memory (
    input  wire logic [13:0] programAddress,
    output dps_pkg::dps_op_t op,
    output logic             condTrue,
    output logic             condIsCe,
    output logic [13:0]      jumpAddr,
    output logic [13:0]      loopEndAddr,
    output logic [3:0]       loopCond
);
    logic [37:0] mem [0:16383];
    logic [37:0] word;
    initial begin
        for (int i = 0; i < 16384; i++) begin
            mem[i] = 38'h0000000000;
        end
    end
    assign word = mem[programAddress];
    assign op = dps_pkg::dps_op_t'(word[37:34]);
    assign {condTrue, condIsCe, jumpAddr, loopEndAddr, loopCond} = word[33:0];
endmodule // dps_program_memory

// ---- test/dps_program_sequencer_tb.sv ----
// Purpose: Self-checking bench of the program sequencer.
// Assumes: Program memory model feeds the decoder inputs.
// Notes:   Each scenario leaves the sequencer parked on a self jump, except interrupts, which leaves it on an idle.
`timescale 1ns/1ps
module dps_program_sequencer_tb;
    logic             sys_clk;
    logic             reset;
    logic [7:0]       wbAdr;
    logic [31:0]      wbDatIn;
    logic             wbWe;
    logic             wbCyc;
    logic             wbStb;
    logic             wbAck;
    logic [31:0]      wbDatOut;
    dps_pkg::dps_op_t op;
    logic             condTrue;
    logic             condIsCe;
    logic [13:0]      jumpAddr;
    logic [13:0]      loopEndAddr;
    logic [3:0]       loopCond;
    logic             irqTake;
    logic [2:0]       irqLevel;
    logic [5:0]       flags;
    logic [13:0]      programAddress;
    logic             stackError;
    logic [31:0]      rd;
    int               mismatches = 0;
    int               testsRun = 0;

    dps_program_sequencer dut (
        .sys_clk(sys_clk), .reset(reset), .wbAdr(wbAdr), .wbDatIn(wbDatIn),
        .wbSel(4'hF), .wbWe(wbWe), .wbCyc(wbCyc), .wbStb(wbStb),
        .wbAck(wbAck), .wbDatOut(wbDatOut), .op(op), .condTrue(condTrue),
        .condIsCe(condIsCe), .jumpAddr(jumpAddr), .loopEndAddr(loopEndAddr),
        .loopCond(loopCond), .indirectAddr(14'h0060), .irqTake(irqTake),
        .irqLevel(irqLevel), .aluZeroFlag(flags[0]),
        .aluNegativeFlag(flags[1]), .aluOverflowFlag(flags[2]),
        .aluCarryFlag(flags[3]), .macOverflowFlag(flags[4]),
        .xInputSignFlag(flags[5]), .programAddress(programAddress),
        .stackError(stackError));
    dps_program_memory pm (
        .programAddress(programAddress), .op(op), .condTrue(condTrue),
        .condIsCe(condIsCe), .jumpAddr(jumpAddr), .loopEndAddr(loopEndAddr),
        .loopCond(loopCond));

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic we,
                        input logic [31:0] d);
        @(posedge sys_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatIn <= d;
        do begin
            @(posedge sys_clk);
        end while (wbAck !== 1'b1);
        rd = wbDatOut;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask
    task automatic readCheck(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h00000000);
        check(rd, exp);
    endtask
    // Word write lands at a clock edge; jump and loop end fields get the same value
    task automatic put(input logic [13:0] a, input dps_pkg::dps_op_t o,
                       input logic t, input logic [13:0] j,
                       input logic [3:0] c);
        @(posedge sys_clk);
        pm.mem[a] <= {o, t, 1'b0, j, j, c};
    endtask
    task automatic follow(input logic [13:0] a);
        @(posedge sys_clk);
        #1;
        check({18'h00000, programAddress}, {18'h00000, a});
    endtask
    task automatic waitPc(input logic [13:0] a);
        int n = 0;
        while (programAddress !== a && n < 200) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check({18'h00000, programAddress}, {18'h00000, a});
    endtask

    task automatic resetValues();
        readCheck(8'h08, 32'h00000007);
        readCheck(8'h00, 32'h00000000);
        readCheck(8'h10, 32'h00000000);
    endtask
    task automatic countStack();
        xfer(8'h00, 1'b1, 32'hFFFFC005);
        readCheck(8'h00, 32'h00000005);
        readCheck(8'h08, 32'h0000000F);
        xfer(8'h00, 1'b1, 32'h00000003);
        readCheck(8'h08, 32'h0000000D);
        xfer(8'h04, 1'b1, 32'h00000002);
        readCheck(8'h00, 32'h00000002);
        readCheck(8'h08, 32'h0000000D);
    endtask
    task automatic ceLoop();
        logic [13:0] s [6] = '{14'h31, 14'h32, 14'h31, 14'h32, 14'h33, 14'h33};
        put(14'h30, dps_pkg::DPS_OP_DO, 1'b1, 14'h32, 4'hE);
        put(14'h33, dps_pkg::DPS_OP_JUMP, 1'b1, 14'h33, 4'h0);
        put(14'h00, dps_pkg::DPS_OP_JUMP, 1'b1, 14'h30, 4'h0);
        waitPc(14'h30);
        foreach (s[i]) follow(s[i]);
        readCheck(8'h00, 32'h00000005);
        readCheck(8'h08, 32'h0000000F);
    endtask
    task automatic interrupts();
        put(14'h33, dps_pkg::DPS_OP_IDLE, 1'b1, 14'h33, 4'h0);
        for (int l = 0; l < 6; l++) begin
            put(14'((l + 1) * 4), dps_pkg::DPS_OP_RTI, 1'b1, 14'h00, 4'h0);
            irqLevel <= 3'(l);
            irqTake <= 1'b1;
            @(posedge sys_clk);
            irqTake <= 1'b0;
            #1;
            check({18'h00000, programAddress}, 32'((l + 1) * 4));
            follow(14'h33);
        end
    endtask
    task automatic callIndirect();
        logic [13:0] s [5] = '{14'h50, 14'h41, 14'h42, 14'h60, 14'h60};
        put(14'h40, dps_pkg::DPS_OP_CALL, 1'b1, 14'h50, 4'h0);
        put(14'h50, dps_pkg::DPS_OP_RTS, 1'b1, 14'h00, 4'h0);
        put(14'h41, dps_pkg::DPS_OP_JUMP, 1'b0, 14'h70, 4'h0);
        put(14'h42, dps_pkg::DPS_OP_INDIRECT, 1'b1, 14'h00, 4'h0);
        put(14'h60, dps_pkg::DPS_OP_JUMP, 1'b1, 14'h60, 4'h0);
        put(14'h33, dps_pkg::DPS_OP_JUMP, 1'b1, 14'h40, 4'h0);
        waitPc(14'h40);
        foreach (s[i]) follow(s[i]);
    endtask
    task automatic condLoops();
        logic [3:0] c [14] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
                               4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD};
        logic [5:0] f [14] = '{6'h00, 6'h01, 6'h00, 6'h02, 6'h00, 6'h01,
                               6'h00, 6'h08, 6'h00, 6'h04, 6'h00, 6'h10,
                               6'h00, 6'h20};
        logic [5:0] t [14] = '{6'h01, 6'h00, 6'h02, 6'h00, 6'h01, 6'h00,
                               6'h08, 6'h00, 6'h04, 6'h00, 6'h10, 6'h00,
                               6'h20, 6'h00};
        put(14'h63, dps_pkg::DPS_OP_JUMP, 1'b1, 14'h60, 4'h0);
        for (int i = 0; i < 14; i++) begin
            put(14'h61, dps_pkg::DPS_OP_DO, 1'b1, 14'h62, c[i]);
            flags <= f[i];
            put(14'h60, dps_pkg::DPS_OP_JUMP, 1'b1, 14'h61, 4'h0);
            waitPc(14'h62);
            put(14'h60, dps_pkg::DPS_OP_JUMP, 1'b1, 14'h60, 4'h0);
            flags <= t[i];
            #1;
            check({18'h00000, programAddress}, 32'h00000062);
            follow(14'h63);
        end
    endtask
    task automatic stackFault();
        xfer(8'h0C, 1'b1, 32'h00000001);
        readCheck(8'h08, 32'h0000020F);
        check({31'h00000000, stackError}, 32'h00000001);
        readCheck(8'h00, 32'h00000005);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        #500000;
        mismatches++;
        conclude();
    end
    initial begin
        reset = 1'b1;
        wbAdr = 8'h00;
        wbDatIn = 32'h00000000;
        wbWe = 1'b0;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        irqTake = 1'b0;
        irqLevel = 3'h0;
        flags = 6'h00;
        put(14'h00, dps_pkg::DPS_OP_JUMP, 1'b1, 14'h00, 4'h0);
        repeat (19) @(posedge sys_clk);
        reset <= 1'b0;
        follow(14'h00);
        resetValues();
        countStack();
        ceLoop();
        interrupts();
        callIndirect();
        condLoops();
        stackFault();
        conclude();
    end
endmodule // dps_program_sequencer_tb

// ---- test/dps_sequencer_assertions.sv ----
// Purpose: Port-level checks of the program sequencer.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Bound to the design at the foot of this file.
`timescale 1ns/1ps
module dps_sequencer_assertions (
    input wire logic             sys_clk,
    input wire logic             reset,
    input wire logic             wbCyc,
    input wire logic             wbStb,
    input wire logic             wbAck,
    input wire logic [31:0]      wbDatOut,
    input wire dps_pkg::dps_op_t op,
    input wire logic             condTrue,
    input wire logic             condIsCe,
    input wire logic [13:0]      jumpAddr,
    input wire logic [13:0]      indirectAddr,
    input wire logic             irqTake,
    input wire logic [2:0]       irqLevel,
    input wire logic [13:0]      programAddress,
    input wire logic             stackError
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic taken;
    assign taken = condTrue && !condIsCe && !irqTake;

    property p_jump;
        op == dps_pkg::DPS_OP_JUMP && taken |=>
            programAddress == $past(jumpAddr);
    endproperty
    a_jump: assert property (p_jump)
        else $error("jump target not taken");
    property p_call;
        op == dps_pkg::DPS_OP_CALL && taken |=>
            programAddress == $past(jumpAddr);
    endproperty
    a_call: assert property (p_call)
        else $error("call target not taken");
    property p_ind;
        op == dps_pkg::DPS_OP_INDIRECT && taken |=>
            programAddress == $past(indirectAddr);
    endproperty
    a_ind: assert property (p_ind)
        else $error("indirect target not loaded");
    property p_vec;
        irqTake |=>
            programAddress == {8'h00, {1'b0, $past(irqLevel)} + 4'h1, 2'h0};
    endproperty
    a_vec: assert property (p_vec)
        else $error("wrong interrupt vector");
    property p_ack;
        wbCyc && wbStb && !wbAck |=> wbAck ##1 !wbAck;
    endproperty
    a_ack: assert property (p_ack)
        else $error("bus answer out of step");
    property p_pad;
        wbAck |-> wbDatOut[31:14] == 18'h00000;
    endproperty
    a_pad: assert property (p_pad)
        else $error("upper read bits not zero");
    property p_idle;
        !wbAck |-> wbDatOut == 32'h00000000;
    endproperty
    a_idle: assert property (p_idle)
        else $error("read data outside answer");
    property p_sticky;
        stackError |=> stackError [*3];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("stack fault flag lost");
    property p_start;
        $fell(reset) |-> programAddress == 14'h0000 && !stackError;
    endproperty
    a_start: assert property (p_start)
        else $error("state after reset wrong");

    c_irq: cover property (irqTake);
    c_ind: cover property (op == dps_pkg::DPS_OP_INDIRECT && taken);
    c_read: cover property (wbAck && wbDatOut != 32'h00000000);
endmodule // dps_sequencer_assertions

bind dps_program_sequencer dps_sequencer_assertions u_chk (
    .sys_clk(sys_clk), .reset(reset), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbAck(wbAck), .wbDatOut(wbDatOut), .op(op), .condTrue(condTrue),
    .condIsCe(condIsCe), .jumpAddr(jumpAddr), .indirectAddr(indirectAddr),
    .irqTake(irqTake), .irqLevel(irqLevel),
    .programAddress(programAddress), .stackError(stackError));
